// ---- common/dzpcg_defs.svh ----
// Offsets, field positions, reset values and timing counts of the doze and gating block
`ifndef DZPCG_DEFS_SVH
`define DZPCG_DEFS_SVH
`define DZ_OFS_DIV 8'h00
`define DZ_OFS_G1 8'h04
`define DZ_OFS_G2 8'h08
`define DZ_OFS_G3 8'h0C
`define DZ_OFS_STAT 8'h10
`define DZ_RET_INT_BIT 15
`define DZ_RATIO_HI 14
`define DZ_RATIO_LO 12
`define DZ_SLOW_EN_BIT 11
`define DZ_DIV_RST 16'h0000
`define DZ_GATE_RST 16'h0000
`define DZ_G1_IMPL 16'hFEFB
`define DZ_G2_IMPL 16'hC30F
`define DZ_G3_IMPL 16'h07F0
`define DZ_CLK_NS 20
`define DZ_WAKE_CYC 2
`define DZ_RESP_OKAY 2'b00
`define DZ_RESP_SLVERR 2'b10
`endif

// ---- common/dzpcg_pkg.sv ----
// Types shared by the doze and gating block
package dzpcg_pkg;
    typedef enum logic [2:0] {
        DZ_RUN = 3'b000,
        DZ_ENTER = 3'b001,
        DZ_SLEEP = 3'b010,
        DZ_IDLE = 3'b011,
        DZ_WAKE = 3'b100
    } dzpcg_state_e;
    typedef struct packed {
        logic return_on_interrupt;
        logic [2:0] ratio;
        logic cpu_slowdown_enable;
    } dzpcg_div_s;
    typedef struct packed {
        logic [15:0] gate3;
        logic [15:0] gate2;
        logic [15:0] gate1;
    } dzpcg_gate_s;
endpackage

// ---- core/dzpcg_doze_div.sv ----
// CPU clock-enable divider locked to the peripheral clock
module dzpcg_doze_div
    import dzpcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slowdown,
    input wire logic [2:0] ratio,
    output logic tick
);
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] mask;
    // One free-running counter on the system clock keeps both domains in step
    always_comb begin
        cnt_d = cnt_q + 7'h01;
        mask = 7'(8'h01 << ratio) - 7'h01;
        tick = !slowdown || ((cnt_q & mask) == 7'h00);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    property p_full_rate;
        @(posedge clk) disable iff (rst) !slowdown |-> tick;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("CPU tick missing with doze off");
endmodule

// ---- core/dzpcg_top.sv ----
// Doze divider, power-save sequencing and peripheral clock gating with AXI4-Lite registers
`include "dzpcg_defs.svh"

module dzpcg_top
    import dzpcg_pkg::*;
#(
    parameter logic [15:0] PRESENT1 = `DZ_G1_IMPL,
    parameter logic [15:0] PRESENT2 = `DZ_G2_IMPL,
    parameter logic [15:0] PRESENT3 = `DZ_G3_IMPL
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic power_save_instruction,
    input wire logic power_save_sleep,
    input wire logic irq_pend,
    output logic cpu_clk_en,
    output logic sys_clk_run,
    output logic cpu_halted,
    output logic [47:0] mod_clk_en,
    input wire logic [47:0] periph_wr_in,
    output logic [47:0] periph_wr_out
);
    localparam logic [47:0] PRESENT = {PRESENT3, PRESENT2, PRESENT1};
    localparam logic [47:0] IMPL = {`DZ_G3_IMPL, `DZ_G2_IMPL, `DZ_G1_IMPL};
    localparam logic [1:0] WAKE_CNT = 2'(`DZ_WAKE_CYC - 1);

    // Register index: 0 divider, 1..3 gates, 4 status, 7 unmapped
    function automatic logic [2:0] dec(input logic [7:0] a);
        case (a)
            `DZ_OFS_DIV: dec = 3'h0;
            `DZ_OFS_G1: dec = 3'h1;
            `DZ_OFS_G2: dec = 3'h2;
            `DZ_OFS_G3: dec = 3'h3;
            `DZ_OFS_STAT: dec = 3'h4;
            default: dec = 3'h7;
        endcase
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge = old;
        if (st[0]) begin
            merge[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge[15:8] = wd[15:8];
        end
    endfunction

    // Bus slave state
    logic aw_hold_q;
    logic aw_hold_d;
    logic [7:0] aw_addr_q;
    logic [7:0] aw_addr_d;
    logic w_hold_q;
    logic w_hold_d;
    logic [31:0] w_data_q;
    logic [31:0] w_data_d;
    logic [3:0] w_strb_q;
    logic [3:0] w_strb_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic do_wr;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;

    // Control state
    dzpcg_div_s div_q;
    dzpcg_div_s div_d;
    dzpcg_gate_s gate_q;
    dzpcg_gate_s gate_d;
    logic [47:0] run_q;
    logic [47:0] run_d;
    dzpcg_state_e state_q;
    dzpcg_state_e state_d;
    logic sleep_sel_q;
    logic sleep_sel_d;
    logic defer_q;
    logic defer_d;
    logic [1:0] wake_q;
    logic [1:0] wake_d;
    logic tick;
    logic [15:0] div_word;
    logic [15:0] stat_word;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_idx = dec(aw_addr_q);
    assign rd_idx = dec(s_axi_araddr);

    assign div_word = {div_q.return_on_interrupt, div_q.ratio, div_q.cpu_slowdown_enable, 11'h000};
    assign stat_word = {10'h000, defer_q, sleep_sel_q, tick, state_q};

    // Address and data are taken in either order; the write lands once both are held
    always_comb begin
        aw_hold_d = aw_hold_q;
        aw_addr_d = aw_addr_q;
        w_hold_d = w_hold_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_idx == 3'h7) ? `DZ_RESP_SLVERR : `DZ_RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // Status is read-only; unmapped reads answer SLVERR with zero data
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = `DZ_RESP_OKAY;
            case (rd_idx)
                3'h0: rdata_d = {16'h0000, div_word};
                3'h1: rdata_d = {16'h0000, gate_q.gate1 & `DZ_G1_IMPL};
                3'h2: rdata_d = {16'h0000, gate_q.gate2 & `DZ_G2_IMPL};
                3'h3: rdata_d = {16'h0000, gate_q.gate3 & `DZ_G3_IMPL};
                3'h4: rdata_d = {16'h0000, stat_word};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `DZ_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else begin
            aw_hold_q <= aw_hold_d;
            aw_addr_q <= aw_addr_d;
            w_hold_q <= w_hold_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Divider register; a software write in the same cycle wins over the interrupt clear
    always_comb begin
        logic [15:0] nw;
        nw = merge(div_word, w_data_q, w_strb_q);
        div_d = div_q;
        if (irq_pend && div_q.return_on_interrupt) begin
            div_d.cpu_slowdown_enable = 1'b0;
        end
        if (do_wr && wr_idx == 3'h0) begin
            div_d.return_on_interrupt = nw[`DZ_RET_INT_BIT];
            div_d.ratio = nw[`DZ_RATIO_HI:`DZ_RATIO_LO];
            div_d.cpu_slowdown_enable = nw[`DZ_SLOW_EN_BIT];
        end
    end

    // Gate registers hold only implemented bits, so unused positions stay zero
    always_comb begin
        gate_d = gate_q;
        if (do_wr && wr_idx == 3'h1) begin
            gate_d.gate1 = merge(gate_q.gate1, w_data_q, w_strb_q) & `DZ_G1_IMPL;
        end
        if (do_wr && wr_idx == 3'h2) begin
            gate_d.gate2 = merge(gate_q.gate2, w_data_q, w_strb_q) & `DZ_G2_IMPL;
        end
        if (do_wr && wr_idx == 3'h3) begin
            gate_d.gate3 = merge(gate_q.gate3, w_data_q, w_strb_q) & `DZ_G3_IMPL;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= dzpcg_div_s'(5'h00);
            gate_q <= dzpcg_gate_s'({3{`DZ_GATE_RST}});
        end else begin
            div_q <= div_d;
            gate_q <= gate_d;
        end
    end

    // One stage per bit gives the one-cycle delay after the stored write
    genvar gi;
    generate
        for (gi = 0; gi < 48; gi++) begin : g_run
            always_comb begin
                run_d[gi] = PRESENT[gi] && IMPL[gi] && !gate_q[gi];
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    run_q[gi] <= 1'b0;
                end else begin
                    run_q[gi] <= run_d[gi];
                end
            end
            assign mod_clk_en[gi] = run_q[gi] && sys_clk_run;
            assign periph_wr_out[gi] = periph_wr_in[gi] && run_q[gi];
        end
    endgenerate

    dzpcg_doze_div u_div (
        .clk(clk),
        .rst(rst),
        .slowdown(div_q.cpu_slowdown_enable),
        .ratio(div_q.ratio),
        .tick(tick)
    );

    // Power-save sequencing: the entry cycle cannot be woken, the wake is remembered
    always_comb begin
        state_d = state_q;
        sleep_sel_d = sleep_sel_q;
        defer_d = defer_q;
        wake_d = wake_q;
        case (state_q)
            DZ_RUN: begin
                if (power_save_instruction && tick) begin
                    state_d = DZ_ENTER;
                    sleep_sel_d = power_save_sleep;
                end
            end
            DZ_ENTER: begin
                if (irq_pend) begin
                    defer_d = 1'b1;
                end
                state_d = sleep_sel_q ? DZ_SLEEP : DZ_IDLE;
            end
            DZ_SLEEP, DZ_IDLE: begin
                if (irq_pend || defer_q) begin
                    state_d = DZ_WAKE;
                    defer_d = 1'b0;
                    wake_d = WAKE_CNT;
                end
            end
            DZ_WAKE: begin
                if (wake_q == 2'h0) begin
                    state_d = DZ_RUN;
                end else begin
                    wake_d = wake_q - 2'h1;
                end
            end
            default: state_d = DZ_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= DZ_RUN;
            sleep_sel_q <= 1'b0;
            defer_q <= 1'b0;
            wake_q <= 2'h0;
        end else begin
            state_q <= state_d;
            sleep_sel_q <= sleep_sel_d;
            defer_q <= defer_d;
            wake_q <= wake_d;
        end
    end

    assign cpu_clk_en = (state_q == DZ_RUN) && tick;
    assign sys_clk_run = (state_q != DZ_SLEEP);
    assign cpu_halted = (state_q != DZ_RUN);

    property p_enter_done;
        @(posedge clk) disable iff (rst)
        state_q == DZ_ENTER |=> state_q inside {DZ_SLEEP, DZ_IDLE};
    endproperty
    a_enter_done: assert property (p_enter_done) else $error("Entry not completed");

    property p_defer_wake;
        @(posedge clk) disable iff (rst)
        (state_q == DZ_ENTER && irq_pend) |=> ##1 state_q == DZ_WAKE;
    endproperty
    a_defer_wake: assert property (p_defer_wake) else $error("Held-off interrupt lost");

    property p_wake_time;
        @(posedge clk) disable iff (rst)
        (state_q inside {DZ_SLEEP, DZ_IDLE} && irq_pend) |=> state_q == DZ_WAKE ##1 state_q == DZ_WAKE
            ##1 (state_q == DZ_RUN && !cpu_halted);
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("Wake latency wrong");

    property p_full_speed;
        @(posedge clk) disable iff (rst)
        (state_q == DZ_RUN && !div_q.cpu_slowdown_enable) |-> cpu_clk_en;
    endproperty
    a_full_speed: assert property (p_full_speed) else $error("CPU slowed with doze off");

    property p_half_rate;
        @(posedge clk) disable iff (rst)
        (cpu_clk_en && div_q.cpu_slowdown_enable && div_q.ratio == 3'h1 && !do_wr && !irq_pend)
            |=> !cpu_clk_en;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("Ratio 1 not halving");

    property p_ret_int;
        @(posedge clk) disable iff (rst)
        (irq_pend && div_q.return_on_interrupt && !do_wr) |=> !div_q.cpu_slowdown_enable;
    endproperty
    a_ret_int: assert property (p_ret_int) else $error("Interrupt did not end doze");

    property p_no_ret_int;
        @(posedge clk) disable iff (rst)
        (div_q.cpu_slowdown_enable && !div_q.return_on_interrupt && !do_wr) |=> div_q.cpu_slowdown_enable;
    endproperty
    a_no_ret_int: assert property (p_no_ret_int) else $error("Doze ended without cause");

    // Sleep also stops the clock, so only a running, present module shows the lag
    property p_gate_delay;
        @(posedge clk) disable iff (rst)
        ($rose(gate_q.gate1[0]) && sys_clk_run && PRESENT[0]) |-> mod_clk_en[0] ##1 !mod_clk_en[0];
    endproperty
    a_gate_delay: assert property (p_gate_delay) else $error("Gate delay wrong");

    property p_wr_block;
        @(posedge clk) disable iff (rst)
        (periph_wr_out & ~run_q) == 48'h0;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("Write reached gated peripheral");

    property p_unimpl_zero;
        @(posedge clk) disable iff (rst)
        (gate_q & ~IMPL) == 48'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented gate bit set");

    c_slow_max: cover property (@(posedge clk) disable iff (rst)
        div_q.cpu_slowdown_enable && div_q.ratio == 3'h7 && cpu_clk_en);
    c_sleep_wake: cover property (@(posedge clk) disable iff (rst)
        state_q == DZ_SLEEP ##1 state_q == DZ_WAKE);
    c_deferred: cover property (@(posedge clk) disable iff (rst) state_q == DZ_ENTER && irq_pend);
    c_ret_int: cover property (@(posedge clk) disable iff (rst) $fell(div_q.cpu_slowdown_enable) && !do_wr);
endmodule

// ---- dv/dzpcg_top_test.sv ----
// Self-checking testbench for the doze and peripheral clock gating block
`include "dzpcg_defs.svh"
module dzpcg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] PRESENT = {`DZ_G3_IMPL, `DZ_G2_IMPL, `DZ_G1_IMPL};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic psi = 1'b0, pss = 1'b0, irq = 1'b0;
    logic [47:0] pwr_in = {48{1'b1}}, pwr_out, mod_clk_en, mod_at_b;
    logic awready, wready, bvalid, arready, rvalid, cpu_clk_en, sys_clk_run, cpu_halted;
    logic [1:0] bresp, rresp;
    int error_cnt = 0;
    int check_count = 0;

    always #(`DZ_CLK_NS / 2) clk = ~clk;

    dzpcg_top uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_save_instruction(psi),
        .power_save_sleep(pss), .irq_pend(irq), .cpu_clk_en(cpu_clk_en), .sys_clk_run(sys_clk_run),
        .cpu_halted(cpu_halted), .mod_clk_en(mod_clk_en), .periph_wr_in(pwr_in), .periph_wr_out(pwr_out));

    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // Address and data are offered together; each is dropped only after its own handshake edge
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        logic ta, tw, da, dw;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {16'h0000, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        da = 1'b0;
        dw = 1'b0;
        while (!(da && dw)) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            da = da || ta;
            dw = dw || tw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        r = bresp;
        mod_at_b = mod_clk_en;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        chk("bresp", `DZ_RESP_OKAY, r);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk(what, {16'h0000, exp}, d);
        chk("rresp", `DZ_RESP_OKAY, r);
    endtask

    task automatic test_reset();
        rd_chk("divider", `DZ_OFS_DIV, `DZ_DIV_RST);
        rd_chk("gate1", `DZ_OFS_G1, `DZ_GATE_RST);
        rd_chk("gate2", `DZ_OFS_G2, `DZ_GATE_RST);
        rd_chk("gate3", `DZ_OFS_G3, `DZ_GATE_RST);
        chk("mod_clk_en", PRESENT, mod_clk_en);
        chk("periph_wr_out", PRESENT, pwr_out);
        rd_chk("status", `DZ_OFS_STAT, 16'h0008);
        // Strobes must pass per bit, not merely follow the clock enables
        pwr_in <= 48'hA5A5_5A5A_0F0F;
        @(negedge clk);
        chk("periph_wr_out pattern", PRESENT & 48'hA5A5_5A5A_0F0F, pwr_out);
        @(posedge clk);
        pwr_in <= {48{1'b1}};
        $display("test reset done");
    endtask

    task automatic test_gates();
        logic [7:0] a;
        for (int k = 0; k < 3; k++) begin
            a = `DZ_OFS_G1 + 8'(k * 4);
            wr(a, 16'hFFFF);
            rd_chk("gate readback", a, PRESENT[k*16 +: 16]);
        end
        chk("mod_clk_en all gated", 48'h0, mod_clk_en);
        chk("periph_wr_out gated", 48'h0, pwr_out);
        for (int k = 0; k < 3; k++) wr(`DZ_OFS_G1 + 8'(k * 4), 16'h0000);
        // Each present bit alone: position, one-cycle lag on set and on clear
        for (int i = 0; i < 48; i++) begin
            if (PRESENT[i]) begin
                a = `DZ_OFS_G1 + 8'((i / 16) * 4);
                wr(a, 16'h0001 << (i % 16));
                chk("mod_clk_en before lag", PRESENT, mod_at_b);
                @(negedge clk);
                chk("mod_clk_en one gate", PRESENT & ~(48'h1 << i), mod_clk_en);
                chk("periph_wr_out one gate", PRESENT & ~(48'h1 << i), pwr_out);
                wr(a, 16'h0000);
                chk("mod_clk_en re-enable lag", PRESENT & ~(48'h1 << i), mod_at_b);
            end
        end
        $display("test gates done");
    endtask

    task automatic test_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(8'h14, 16'hFFFF, r);
        chk("unmapped bresp", `DZ_RESP_SLVERR, r);
        axi_read(8'hFC, d, r);
        chk("unmapped rresp", `DZ_RESP_SLVERR, r);
        chk("unmapped rdata", 48'h0, d);
        $display("test unmapped done");
    endtask

    task automatic test_doze();
        int cnt;
        logic ok;
        for (int n = 0; n < 8; n++) begin
            wr(`DZ_OFS_DIV, 16'h0800 | 16'(n << 12));
            cnt = 0;
            ok = 1'b1;
            // Window of 256 is a multiple of every ratio, so the count is exact
            repeat (256) begin
                @(negedge clk);
                if (cpu_clk_en === 1'b1) cnt++;
                if (mod_clk_en !== PRESENT || sys_clk_run !== 1'b1) ok = 1'b0;
            end
            chk("cpu ticks", 48'(256 >> n), 48'(cnt));
            chk("periph clock full rate", 48'h1, 48'(ok));
        end
        wr(`DZ_OFS_DIV, 16'h7000);
        cnt = 0;
        repeat (16) begin
            @(negedge clk);
            if (cpu_clk_en === 1'b1) cnt++;
        end
        chk("cpu ticks doze off", 48'd16, 48'(cnt));
        $display("test doze done");
    endtask

    task automatic pulse_irq();
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
    endtask

    task automatic test_ret_int();
        wr(`DZ_OFS_DIV, 16'hB800);
        pulse_irq();
        rd_chk("divider after irq ret on", `DZ_OFS_DIV, 16'hB000);
        wr(`DZ_OFS_DIV, 16'h3800);
        pulse_irq();
        rd_chk("divider after irq ret off", `DZ_OFS_DIV, 16'h3800);
        wr(`DZ_OFS_DIV, 16'h0000);
        $display("test return on interrupt done");
    endtask

    task automatic test_idle();
        int n;
        logic sr;
        @(posedge clk);
        psi <= 1'b1;
        pss <= 1'b0;
        @(posedge clk);
        psi <= 1'b0;
        irq <= 1'b1;
        n = 0;
        sr = 1'b1;
        @(negedge clk);
        if (cpu_halted === 1'b1) n++;
        @(posedge clk);
        irq <= 1'b0;
        repeat (11) begin
            @(negedge clk);
            if (cpu_halted === 1'b1) n++;
            if (sys_clk_run !== 1'b1) sr = 1'b0;
        end
        chk("deferred wake", 48'h1, 48'(n >= 3 && n <= 6));
        chk("idle keeps sys clock", 48'h1, 48'(sr));
        chk("cpu_halted after wake", 48'h0, 48'(cpu_halted));
        $display("test idle done");
    endtask

    task automatic test_sleep();
        int n;
        @(posedge clk);
        psi <= 1'b1;
        pss <= 1'b1;
        @(posedge clk);
        psi <= 1'b0;
        repeat (6) @(negedge clk);
        chk("sleep halted", 48'h1, 48'(cpu_halted));
        chk("sleep sys clock", 48'h0, 48'(sys_clk_run));
        chk("sleep mod clocks", 48'h0, mod_clk_en);
        pulse_irq();
        n = 0;
        repeat (8) begin
            @(negedge clk);
            if (cpu_halted === 1'b1) n++;
        end
        chk("sleep wake latency", 48'h1, 48'(n <= 4));
        chk("wake sys clock", 48'h1, 48'(sys_clk_run));
        chk("wake mod clocks", PRESENT, mod_clk_en);
        rd_chk("status after sleep", `DZ_OFS_STAT, 16'h0018);
        $display("test sleep done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Longest test needs about 2200 cycles of doze counting; the rest is well under that
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_unmapped();
        test_gates();
        test_doze();
        test_ret_int();
        test_idle();
        test_sleep();
        print_verdict();
    end
endmodule
